// ==== rtl/evx_params.svh ====
// Constants for the exception vector 3 to 7 detection block
`ifndef EVX_PARAMS_SVH
`define EVX_PARAMS_SVH

// Vector numbers presented to the dispatcher
`define EVX_VEC_BREAKPOINT 8'h03
`define EVX_VEC_OVERFLOW 8'h04
`define EVX_VEC_RANGE 8'h05
`define EVX_VEC_INVALID_OP 8'h06
`define EVX_VEC_DEV_ABSENT 8'h07

// Immediate of the software interrupt that maps onto the breakpoint
`define EVX_BP_IMM 8'h03

// Reserved opcodes that raise no invalid-opcode fault unless a bad atomic prefix or bad operand type is present
`define EVX_OPC_QUIET_A 8'hD6
`define EVX_OPC_QUIET_B 8'hF1

// Feature word bit positions
`define EVX_FEAT_PKINT 23
`define EVX_FEAT_SIMD1 25
`define EVX_FEAT_SIMD2 26
// Counter-register feature word bit positions
`define EVX_FEATC_SIMD3 0
`define EVX_FEATC_SIMD4 9

// Reset value of the registered exception record
`define EVX_VEC_RESET 8'h00

`endif

// ==== rtl/evx_pkg.sv ====
// Types shared by the exception vector 3 to 7 detection block
package evx_pkg;

  // Instruction kinds reported by the decoder at retire
  typedef enum logic [3:0] {
    EVX_K_OTHER,
    EVX_K_BREAKPOINT,
    EVX_K_INT_N,
    EVX_K_OVF_CHECK,
    EVX_K_RANGE_CHECK,
    EVX_K_FORCED_UNDEF,
    EVX_K_RESERVED,
    EVX_K_PACKED_INT,
    EVX_K_SIMD,
    EVX_K_X87,
    EVX_K_FPU_SYNC,
    EVX_K_SYS_TABLE,
    EVX_K_LEAVE_SMM
  } evx_kind_e;

  // Operating mode of the retiring instruction
  typedef enum logic [1:0] {
    EVX_M_REAL,
    EVX_M_PROT,
    EVX_M_V86,
    EVX_M_LONG
  } evx_mode_e;

  // Generation of a streaming SIMD instruction
  typedef enum logic [1:0] {
    EVX_G_1,
    EVX_G_2,
    EVX_G_3,
    EVX_G_4
  } evx_gen_e;

  // Exception class
  typedef enum logic {
    EVX_C_FAULT,
    EVX_C_TRAP
  } evx_class_e;

  // Retiring instruction as seen by the block
  typedef struct packed {
    logic valid;
    evx_kind_e kind;
    evx_gen_e gen;
    logic [7:0] opcode;
    logic [7:0] imm;
    logic lock;
    logic lockable;
    logic dest_mem;
    logic operand_bad;
    logic simd_fp_exc;
    logic em_exempt;
    logic osfx_exempt;
    logic ts_exempt;
    logic [31:0] index;
    logic [31:0] lower;
    logic [31:0] upper;
  } evx_retire_s;

  // Control and feature state
  typedef struct packed {
    evx_mode_e mode;
    logic system_mgmt_state;
    logic signed_overflow_flag;
    logic fpu_absent_flag;
    logic task_switched_flag;
    logic monitor_coprocessor_flag;
    logic os_save_support_bit;
    logic os_simd_fault_support_bit;
    logic [31:0] feature_word;
    logic [31:0] counter_reg_c;
  } evx_ctrl_s;

  // Record handed to the dispatcher
  typedef struct packed {
    logic valid;
    logic [7:0] vector;
    evx_class_e cls;
    logic err_code_valid;
    logic ptr_next;
    logic squash;
    logic via_int_n;
  } evx_exc_s;

endpackage : evx_pkg

// ==== rtl/evx_range_chk.sv ====
// Signed index against lower and upper limit comparison
`timescale 1ns/10ps
module evx_range_chk
  import evx_pkg::*;
(
  input wire logic [31:0] index,
  input wire logic [31:0] lower,
  input wire logic [31:0] upper,
  output logic outside
);

  // Index outside the inclusive limits, all signed
  assign outside = ($signed(index) < $signed(lower)) ||
                   ($signed(index) > $signed(upper));

endmodule : evx_range_chk

// ==== rtl/evx_exc_unit.sv ====
// Detection and classification of exception vectors 3 to 7
//
// Functional notes
// - One-byte breakpoint: vector 3 trap, next pointer
// - Software interrupt 3 also gives breakpoint
// - Breakpoint changes no register or memory
// - Overflow check with flag set: vector 4
// - Overflow trap points next, nothing changes
// - Index outside limits: vector 5 fault
// - Range fault restarts check, operands kept
// - Invalid opcode or operand type: vector 6
// - Unsupported SIMD feature bit gives invalid opcode
// - Fpu absent blocks SIMD, listed forms exempt
// - No OS save support blocks streaming SIMD
// - SIMD float fault without OS support: invalid
// - Forced undefined always invalid, points itself
// - Bad atomic prefix gives invalid opcode
// - System table instructions invalid in real/v86
// - Leaving system management outside it: invalid
// - Raised only at retire attempt
// - Opcodes D6 and F1 raise nothing without a bad atomic prefix or bad operand type
// - x87 with fpu absent: vector 7 fault
// - Fpu sync with monitor and task flags: vector 7
// - Task switched, fpu present: vector 7
// - Device-absent fault points at instruction
`timescale 1ns/10ps
`include "evx_params.svh"
module evx_exc_unit
  import evx_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire evx_retire_s ret,
  input wire evx_ctrl_s ctrl,
  output evx_exc_s exc
);

  // Feature support for a packed-integer or streaming SIMD kind
  function automatic logic feat_ok(input evx_kind_e k, input evx_gen_e g,
                                   input logic [31:0] fw,
                                   input logic [31:0] fc);
    logic r;
    r = 1'h1;
    if (k == EVX_K_PACKED_INT)
      r = fw[`EVX_FEAT_PKINT];
    else if (k == EVX_K_SIMD)
    begin
      case (g)
        EVX_G_1: r = fw[`EVX_FEAT_SIMD1];
        EVX_G_2: r = fw[`EVX_FEAT_SIMD2];
        EVX_G_3: r = fc[`EVX_FEATC_SIMD3];
        default: r = fc[`EVX_FEATC_SIMD4];
      endcase
    end
    return r;
  endfunction : feat_ok

  // Kind decode of the retiring instruction
  wire logic is_pk;
  wire logic is_simd;
  wire logic is_x87;
  wire logic is_media;
  wire logic quiet_opc;
  wire logic outside;
  assign is_pk = ret.kind == EVX_K_PACKED_INT;
  assign is_simd = ret.kind == EVX_K_SIMD;
  assign is_x87 = ret.kind == EVX_K_X87;
  assign is_media = is_pk || is_simd;
  assign quiet_opc = (ret.opcode == `EVX_OPC_QUIET_A) ||
                     (ret.opcode == `EVX_OPC_QUIET_B);

  // Limit comparison for the range check instruction
  evx_range_chk u_evx_range_chk
  (
    .index(ret.index),
    .lower(ret.lower),
    .upper(ret.upper),
    .outside(outside)
  );

  // Invalid-opcode causes
  wire logic ud_rsvd;
  wire logic ud_feat;
  wire logic ud_em;
  wire logic ud_osfx;
  wire logic ud_simdfp;
  wire logic ud_forced;
  wire logic ud_lock;
  wire logic ud_sys;
  wire logic ud_smm;
  wire logic ud_any;
  assign ud_rsvd = (ret.kind == EVX_K_RESERVED && !quiet_opc) ||
                   ret.operand_bad;
  assign ud_feat = is_media &&
    !feat_ok(ret.kind, ret.gen, ctrl.feature_word,
             ctrl.counter_reg_c);
  assign ud_em = is_media && ctrl.fpu_absent_flag &&
                 !ret.em_exempt;
  assign ud_osfx = is_simd && !ctrl.os_save_support_bit &&
                   !ret.osfx_exempt;
  assign ud_simdfp = is_simd && ret.simd_fp_exc &&
                     !ctrl.os_simd_fault_support_bit;
  assign ud_forced = ret.kind == EVX_K_FORCED_UNDEF;
  assign ud_lock = ret.lock && (!ret.lockable || !ret.dest_mem);
  assign ud_sys = ret.kind == EVX_K_SYS_TABLE &&
                  (ctrl.mode == EVX_M_REAL ||
                   ctrl.mode == EVX_M_V86);
  assign ud_smm = ret.kind == EVX_K_LEAVE_SMM &&
                  !ctrl.system_mgmt_state;
  assign ud_any = ud_rsvd || ud_feat || ud_em || ud_osfx || ud_simdfp ||
                  ud_forced || ud_lock || ud_sys || ud_smm;

  // Device-absent causes
  wire logic nm_x87;
  wire logic nm_sync;
  wire logic nm_ts;
  wire logic nm_any;
  assign nm_x87 = is_x87 && ctrl.fpu_absent_flag;
  assign nm_sync = ret.kind == EVX_K_FPU_SYNC &&
                   ctrl.monitor_coprocessor_flag &&
                   ctrl.task_switched_flag;
  assign nm_ts = (is_x87 || is_media) && ctrl.task_switched_flag &&
                 !ctrl.fpu_absent_flag && !ret.ts_exempt;
  assign nm_any = nm_x87 || nm_sync || nm_ts;

  // Trap and range causes
  wire logic bp_byte;
  wire logic bp_intn;
  wire logic of_hit;
  wire logic br_hit;
  assign bp_byte = ret.kind == EVX_K_BREAKPOINT;
  assign bp_intn = ret.kind == EVX_K_INT_N &&
                   ret.imm == `EVX_BP_IMM;
  assign of_hit = ret.kind == EVX_K_OVF_CHECK &&
                  ctrl.signed_overflow_flag;
  assign br_hit = ret.kind == EVX_K_RANGE_CHECK && outside;

  // Selection with invalid opcode first, then device absent
  wire logic hit;
  wire logic is_trap;
  wire logic [7:0] sel_vec;
  assign hit = ret.valid &&
               (ud_any || nm_any || bp_byte || bp_intn ||
                of_hit || br_hit);
  assign sel_vec = ud_any ? `EVX_VEC_INVALID_OP :
                   nm_any ? `EVX_VEC_DEV_ABSENT :
                   br_hit ? `EVX_VEC_RANGE :
                   of_hit ? `EVX_VEC_OVERFLOW :
                   `EVX_VEC_BREAKPOINT;
  assign is_trap = !ud_any && !nm_any && !br_hit;

  // Next record; traps point past the instruction, faults at it
  evx_exc_s next_exc;
  always_comb
  begin
    next_exc.valid = hit;
    next_exc.vector = hit ? sel_vec : `EVX_VEC_RESET;
    next_exc.cls = (hit && is_trap) ? EVX_C_TRAP : EVX_C_FAULT;
    next_exc.err_code_valid = 1'h0;
    // Traps let the side-effect-free instruction complete
    next_exc.ptr_next = hit && is_trap;
    // Faults block the instruction so it restarts untouched
    next_exc.squash = hit && !is_trap;
    next_exc.via_int_n = hit && is_trap && bp_intn && !of_hit;
  end

  // Registered record to the dispatcher
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      exc <= '0;
    else
      exc <= next_exc;
  end

  // Checks against the registered record
  property p_bp;
    @(posedge core_clk) disable iff (rst)
    (ret.valid && bp_byte && !ud_any && !nm_any) |=>
      (exc.valid && exc.vector == 8'h03 && exc.cls == EVX_C_TRAP &&
       exc.ptr_next && !exc.squash);
  endproperty
  a_bp: assert property (p_bp)
    else $error("breakpoint record wrong");

  property p_intn;
    @(posedge core_clk) disable iff (rst)
    (ret.valid && ret.kind == EVX_K_INT_N && ret.imm == 8'h03 &&
     !ud_lock && !ud_rsvd) |=>
      (exc.vector == 8'h03 && exc.via_int_n);
  endproperty
  a_intn: assert property (p_intn)
    else $error("int n 3 not breakpoint");

  property p_of;
    @(posedge core_clk) disable iff (rst)
    (ret.valid && ret.kind == EVX_K_OVF_CHECK && !ud_any) |=>
      (exc.valid == $past(ctrl.signed_overflow_flag)) &&
      (!exc.valid || (exc.vector == 8'h04 && exc.ptr_next));
  endproperty
  a_of: assert property (p_of)
    else $error("overflow trap wrong");

  property p_br;
    @(posedge core_clk) disable iff (rst)
    (ret.valid && ret.kind == EVX_K_RANGE_CHECK && !ud_any &&
     ($signed(ret.index) > $signed(ret.upper))) |=>
      (exc.vector == 8'h05 && exc.cls == EVX_C_FAULT && exc.squash &&
       !exc.ptr_next);
  endproperty
  a_br: assert property (p_br)
    else $error("range fault wrong");

  property p_quiet;
    @(posedge core_clk) disable iff (rst)
    (ret.valid && ret.kind == EVX_K_RESERVED && !ret.lock &&
     !ret.operand_bad &&
     (ret.opcode == 8'hD6 || ret.opcode == 8'hF1)) |=> !exc.valid;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("quiet opcode faulted");

  property p_ud2;
    @(posedge core_clk) disable iff (rst)
    (ret.valid && ret.kind == EVX_K_FORCED_UNDEF) |=>
      (exc.vector == 8'h06 && !exc.ptr_next && !exc.err_code_valid);
  endproperty
  a_ud2: assert property (p_ud2)
    else $error("forced undefined not invalid");

  property p_retire;
    @(posedge core_clk) disable iff (rst)
    !ret.valid |=> !exc.valid;
  endproperty
  a_retire: assert property (p_retire)
    else $error("exception without retire");

  property p_sync;
    @(posedge core_clk) disable iff (rst)
    (ret.valid && ret.kind == EVX_K_FPU_SYNC && !ud_any &&
     ctrl.monitor_coprocessor_flag && ctrl.task_switched_flag) |=>
      (exc.vector == 8'h07 && exc.squash && !exc.ptr_next);
  endproperty
  a_sync: assert property (p_sync)
    else $error("fpu sync not device absent");

  property p_x87;
    @(posedge core_clk) disable iff (rst)
    (ret.valid && ret.kind == EVX_K_X87 && !ud_any &&
     ctrl.fpu_absent_flag) |=> (exc.vector == 8'h07 && exc.valid);
  endproperty
  a_x87: assert property (p_x87)
    else $error("x87 not device absent");

  property p_ts;
    @(posedge core_clk) disable iff (rst)
    (ret.valid && ret.kind == EVX_K_PACKED_INT && !ud_any &&
     ctrl.task_switched_flag && !ctrl.fpu_absent_flag &&
     !ret.ts_exempt) |=>
      (exc.vector == 8'h07);
  endproperty
  a_ts: assert property (p_ts)
    else $error("task switched not device absent");

  property p_sys;
    @(posedge core_clk) disable iff (rst)
    (ret.valid && ret.kind == EVX_K_SYS_TABLE &&
     ctrl.mode == EVX_M_V86) |=> (exc.vector == 8'h06);
  endproperty
  a_sys: assert property (p_sys)
    else $error("system table in v86 allowed");

  property p_em;
    @(posedge core_clk) disable iff (rst)
    (ret.valid && ret.kind == EVX_K_SIMD && ctrl.fpu_absent_flag &&
     !ret.em_exempt) |=> (exc.vector == 8'h06 && exc.squash);
  endproperty
  a_em: assert property (p_em)
    else $error("simd with fpu absent allowed");

  property p_rsvd;
    @(posedge core_clk) disable iff (rst)
    (ret.valid && ret.operand_bad) |=> (exc.valid && exc.vector == 8'h06);
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("bad operand type not invalid");

  property p_feat;
    @(posedge core_clk) disable iff (rst)
    (ret.valid && ret.kind == EVX_K_PACKED_INT &&
     !ctrl.feature_word[`EVX_FEAT_PKINT]) |=> (exc.vector == 8'h06);
  endproperty
  a_feat: assert property (p_feat)
    else $error("unsupported packed integer allowed");

  property p_osfx;
    @(posedge core_clk) disable iff (rst)
    (ret.valid && ret.kind == EVX_K_SIMD && !ctrl.os_save_support_bit &&
     !ret.osfx_exempt) |=> (exc.vector == 8'h06);
  endproperty
  a_osfx: assert property (p_osfx)
    else $error("simd without os save support allowed");

  property p_simdfp;
    @(posedge core_clk) disable iff (rst)
    (ret.valid && ret.kind == EVX_K_SIMD && ret.simd_fp_exc &&
     !ctrl.os_simd_fault_support_bit) |=> (exc.vector == 8'h06);
  endproperty
  a_simdfp: assert property (p_simdfp)
    else $error("simd float fault not turned invalid");

  property p_lock;
    @(posedge core_clk) disable iff (rst)
    (ret.valid && ret.lock && !ret.dest_mem) |=> (exc.vector == 8'h06);
  endproperty
  a_lock: assert property (p_lock)
    else $error("bad atomic prefix allowed");

  property p_smm;
    @(posedge core_clk) disable iff (rst)
    (ret.valid && ret.kind == EVX_K_LEAVE_SMM && !ctrl.system_mgmt_state)
      |=> (exc.vector == 8'h06);
  endproperty
  a_smm: assert property (p_smm)
    else $error("leaving system management allowed");

  property p_br_low;
    @(posedge core_clk) disable iff (rst)
    (ret.valid && ret.kind == EVX_K_RANGE_CHECK && !ud_any &&
     ($signed(ret.index) < $signed(ret.lower))) |=>
      (exc.valid && exc.vector == 8'h05 && exc.squash &&
       !exc.ptr_next);
  endproperty
  a_br_low: assert property (p_br_low)
    else $error("range fault below limit wrong");

  property p_nm_ptr;
    @(posedge core_clk) disable iff (rst)
    (exc.valid && exc.vector == 8'h07) |->
      (exc.cls == EVX_C_FAULT && exc.squash && !exc.ptr_next);
  endproperty
  a_nm_ptr: assert property (p_nm_ptr)
    else $error("device absent record wrong");

  property p_rec;
    @(posedge core_clk) disable iff (rst)
    exc.valid |-> (exc.vector >= 8'h03 && exc.vector <= 8'h07 &&
      !exc.err_code_valid && exc.squash != exc.ptr_next);
  endproperty
  a_rec: assert property (p_rec)
    else $error("exception record malformed");

endmodule : evx_exc_unit

// ==== test/evx_pipe_model.sv ====
// Retire pipeline and control state model feeding the exception block
`timescale 1ns/10ps
module evx_pipe_model
  import evx_pkg::*;
(
  input wire logic core_clk,
  output evx_retire_s ret,
  output evx_ctrl_s ctrl
);
  // Quiet start: no retire strobe, software keeps the monitor flag set
  initial
  begin
    ret = '0;
    ctrl = '0;
    ctrl.monitor_coprocessor_flag = 1'b1;
  end

  // Present one retiring instruction and its control state for one cycle
  task automatic send(input evx_retire_s r, input evx_ctrl_s c);
    @(posedge core_clk);
    ret <= r;
    ctrl <= c;
  endtask : send

  // Drop the strobe; stale fields are inverted so they never match
  task automatic idle();
    @(posedge core_clk);
    ret <= {1'b0, ~ret[$bits(evx_retire_s)-2:0]};
  endtask : idle
endmodule : evx_pipe_model

// ==== test/exception_vectors_3_to_7_test.sv ====
// Self-checking bench for the exception vector 3 to 7 block
`timescale 1ns/10ps
`include "evx_params.svh"
`define EVX_CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
  fails++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
  end end
module exception_vectors_3_to_7_test
  import evx_pkg::*;
;
  // One table row: kind, gen or range case, byte, retire flags, control
  typedef struct packed {
    logic [3:0] k;
    logic [1:0] g;
    logic [7:0] b;
    logic [7:0] rf;
    logic [8:0] cf;
    logic [4:0] fz;
    logic [7:0] v;
  } evx_row_s;

  logic core_clk;
  logic rst;
  evx_retire_s ret;
  evx_ctrl_s ctrl;
  evx_exc_s exc;
  evx_retire_s tr;
  int fails = 0;
  int checked = 0;
  // Index per range case: inside, below, above, on the lower limit
  logic [31:0] idx [4] = '{32'h00000000, 32'hFFFFFFFA, 32'h0000000B,
    32'hFFFFFFFB};
  evx_row_s rows [42] = '{
    '{4'h1, 2'h0, 8'h00, 8'h00, 9'h087, 5'h00, 8'h03},
    '{4'h5, 2'h0, 8'h00, 8'h00, 9'h087, 5'h00, 8'h06},
    '{4'h9, 2'h0, 8'h00, 8'h00, 9'h097, 5'h00, 8'h07},
    '{4'h9, 2'h0, 8'h00, 8'h00, 9'h087, 5'h00, 8'h00},
    '{4'h2, 2'h0, 8'h03, 8'h00, 9'h087, 5'h00, 8'h03},
    '{4'h2, 2'h0, 8'h04, 8'h00, 9'h087, 5'h00, 8'h00},
    '{4'h3, 2'h0, 8'h00, 8'h00, 9'h0A7, 5'h00, 8'h04},
    '{4'h3, 2'h0, 8'h00, 8'h00, 9'h087, 5'h00, 8'h00},
    '{4'h4, 2'h2, 8'h00, 8'h00, 9'h087, 5'h00, 8'h05},
    '{4'h4, 2'h1, 8'h00, 8'h00, 9'h087, 5'h00, 8'h05},
    '{4'h4, 2'h3, 8'h00, 8'h00, 9'h087, 5'h00, 8'h00},
    '{4'h6, 2'h0, 8'h0F, 8'h00, 9'h087, 5'h00, 8'h06},
    '{4'h6, 2'h0, 8'hD6, 8'h00, 9'h087, 5'h00, 8'h00},
    '{4'h6, 2'h0, 8'hF1, 8'h00, 9'h087, 5'h00, 8'h00},
    '{4'h0, 2'h0, 8'h00, 8'h10, 9'h087, 5'h00, 8'h06},
    '{4'h7, 2'h0, 8'h00, 8'h00, 9'h087, 5'h01, 8'h06},
    '{4'h8, 2'h0, 8'h00, 8'h00, 9'h087, 5'h02, 8'h06},
    '{4'h8, 2'h1, 8'h00, 8'h00, 9'h087, 5'h04, 8'h06},
    '{4'h8, 2'h2, 8'h00, 8'h00, 9'h087, 5'h08, 8'h06},
    '{4'h8, 2'h3, 8'h00, 8'h00, 9'h087, 5'h10, 8'h06},
    '{4'h8, 2'h0, 8'h00, 8'h00, 9'h087, 5'h1D, 8'h00},
    '{4'h7, 2'h0, 8'h00, 8'h00, 9'h097, 5'h00, 8'h06},
    '{4'h8, 2'h0, 8'h00, 8'h04, 9'h097, 5'h00, 8'h00},
    '{4'h8, 2'h0, 8'h00, 8'h00, 9'h085, 5'h00, 8'h06},
    '{4'h8, 2'h0, 8'h00, 8'h02, 9'h085, 5'h00, 8'h00},
    '{4'h7, 2'h0, 8'h00, 8'h00, 9'h085, 5'h00, 8'h00},
    '{4'h8, 2'h0, 8'h00, 8'h08, 9'h086, 5'h00, 8'h06},
    '{4'h0, 2'h0, 8'h00, 8'h80, 9'h087, 5'h00, 8'h06},
    '{4'h0, 2'h0, 8'h00, 8'hC0, 9'h087, 5'h00, 8'h06},
    '{4'h0, 2'h0, 8'h00, 8'hE0, 9'h087, 5'h00, 8'h00},
    '{4'hB, 2'h0, 8'h00, 8'h00, 9'h007, 5'h00, 8'h06},
    '{4'hB, 2'h0, 8'h00, 8'h00, 9'h107, 5'h00, 8'h06},
    '{4'hB, 2'h0, 8'h00, 8'h00, 9'h087, 5'h00, 8'h00},
    '{4'hC, 2'h0, 8'h00, 8'h00, 9'h087, 5'h00, 8'h06},
    '{4'hC, 2'h0, 8'h00, 8'h00, 9'h0C7, 5'h00, 8'h00},
    '{4'hA, 2'h0, 8'h00, 8'h00, 9'h09F, 5'h00, 8'h07},
    '{4'hA, 2'h0, 8'h00, 8'h00, 9'h08B, 5'h00, 8'h00},
    '{4'h9, 2'h0, 8'h00, 8'h00, 9'h08F, 5'h00, 8'h07},
    '{4'h8, 2'h0, 8'h00, 8'h00, 9'h08F, 5'h00, 8'h07},
    '{4'h8, 2'h0, 8'h00, 8'h01, 9'h08F, 5'h00, 8'h00},
    '{4'h7, 2'h0, 8'h00, 8'h00, 9'h09F, 5'h00, 8'h06},
    '{4'h4, 2'h2, 8'h00, 8'h10, 9'h087, 5'h00, 8'h06}
  };

  evx_exc_unit u_evx_exc_unit (
    .core_clk(core_clk),
    .rst(rst),
    .ret(ret),
    .ctrl(ctrl),
    .exc(exc)
  );
  evx_pipe_model u_evx_pipe_model (
    .core_clk(core_clk),
    .ret(ret),
    .ctrl(ctrl)
  );

  // Clock at 125 MHz
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Build the retiring instruction of a row
  function automatic evx_retire_s mk_ret(input evx_row_s w);
    evx_retire_s r;
    r = '0;
    r.valid = 1'b1;
    r.kind = evx_kind_e'(w.k);
    r.gen = evx_gen_e'(w.g);
    r.opcode = w.b;
    r.imm = w.b;
    {r.lock, r.lockable, r.dest_mem, r.operand_bad, r.simd_fp_exc,
      r.em_exempt, r.osfx_exempt, r.ts_exempt} = w.rf;
    r.index = idx[w.g];
    r.lower = 32'hFFFFFFFB;
    r.upper = 32'h0000000A;
    return r;
  endfunction : mk_ret

  // Build the control state of a row; fz clears feature bits
  function automatic evx_ctrl_s mk_ctrl(input evx_row_s w);
    evx_ctrl_s c;
    c = '0;
    c.mode = evx_mode_e'(w.cf[8:7]);
    {c.system_mgmt_state, c.signed_overflow_flag, c.fpu_absent_flag,
      c.task_switched_flag, c.monitor_coprocessor_flag,
      c.os_save_support_bit, c.os_simd_fault_support_bit} = w.cf[6:0];
    c.feature_word = 32'hFFFFFFFF;
    c.counter_reg_c = 32'hFFFFFFFF;
    c.feature_word[`EVX_FEAT_PKINT] = !w.fz[0];
    c.feature_word[`EVX_FEAT_SIMD1] = !w.fz[1];
    c.feature_word[`EVX_FEAT_SIMD2] = !w.fz[2];
    c.counter_reg_c[`EVX_FEATC_SIMD3] = !w.fz[3];
    c.counter_reg_c[`EVX_FEATC_SIMD4] = !w.fz[4];
    return c;
  endfunction : mk_ctrl

  // Compare the whole exception record against the expected vector
  task automatic chk_exc(input logic [7:0] v, input logic via);
    logic trap;
    trap = (v == `EVX_VEC_BREAKPOINT) || (v == `EVX_VEC_OVERFLOW);
    `EVX_CHK("valid", v != 8'h00, exc.valid)
    `EVX_CHK("vector", v, exc.vector)
    `EVX_CHK("cls", trap, exc.cls)
    `EVX_CHK("err_code_valid", 1'b0, exc.err_code_valid)
    `EVX_CHK("ptr_next", trap, exc.ptr_next)
    `EVX_CHK("squash", (v != 8'h00) && !trap, exc.squash)
    `EVX_CHK("via_int_n", via, exc.via_int_n)
  endtask : chk_exc

  // Print the counts and the verdict, then stop
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  // Cut a hang short
  initial
  begin
    repeat (2000) @(posedge core_clk);
    fails++;
    $display("Watchdog expired");
    finish_test();
  end

  // Main sequence
  initial
  begin
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk_exc(8'h00, 1'h0);
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk_exc(8'h00, 1'h0);
    $display("Test reset done");
    for (int i = 0; i < 42; i++)
    begin
      u_evx_pipe_model.send(mk_ret(rows[i]), mk_ctrl(rows[i]));
      u_evx_pipe_model.idle();
      #1;
      chk_exc(rows[i].v, (rows[i].k == 4'h2) && (rows[i].v == 8'h03));
    end
    $display("Test table done");
    // Back to back retires, then a faulting kind without the strobe
    tr = mk_ret(rows[1]);
    tr.valid = 1'b0;
    u_evx_pipe_model.send(mk_ret(rows[0]), mk_ctrl(rows[0]));
    u_evx_pipe_model.send(mk_ret(rows[2]), mk_ctrl(rows[2]));
    #1;
    chk_exc(8'h03, 1'b0);
    u_evx_pipe_model.send(mk_ret(rows[1]), mk_ctrl(rows[1]));
    #1;
    chk_exc(8'h07, 1'b0);
    u_evx_pipe_model.idle();
    #1;
    chk_exc(8'h06, 1'b0);
    u_evx_pipe_model.send(tr, mk_ctrl(rows[1]));
    u_evx_pipe_model.idle();
    #1;
    chk_exc(8'h00, 1'b0);
    $display("Test back to back done");
    // Reset in mid-run wipes a pending record
    u_evx_pipe_model.send(mk_ret(rows[1]), mk_ctrl(rows[1]));
    fork
      u_evx_pipe_model.idle();
      @(posedge core_clk) rst <= 1'b1;
    join
    #1;
    chk_exc(8'h00, 1'h0);
    @(posedge core_clk) rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk_exc(8'h00, 1'h0);
    $display("Test mid-run reset done");
    finish_test();
  end
endmodule : exception_vectors_3_to_7_test
